/* rtl/cec_defs.svh */
// offsets, field positions, reset values and counts of the edge conditioner
`ifndef CEC_DEFS_SVH
`define CEC_DEFS_SVH
// register indices; byte address is four times the index
`define CEC_IDX_FILTER 8'h99
`define CEC_IDX_MODE 8'h9c
`define CEC_IDX_APIN 8'haf
`define CEC_IDX_IRQ 8'hb0
// mode control fields
`define CEC_MODE_EN 7
`define CEC_MODE_OEN 6
`define CEC_MODE_RES 5
`define CEC_MODE_SPEC 4
`define CEC_MODE_EDGE 3
`define CEC_MODE_DSEL 2
// analog pin configuration fields
`define CEC_APIN_NEG 1
`define CEC_APIN_POS 0
// interrupt / timer control fields
`define CEC_IRQ_FLAG 0
`define CEC_IRQ_IEN 1
`define CEC_IRQ_TPO 2
`define CEC_IRQ_RUN 3
// reset values
`define CEC_FILT_RST 8'h00
`define CEC_MODE_RST 8'h00
`define CEC_APIN_RST 2'h0
// stage counter width and bus answers
`define CEC_CNT_W 4
`define CEC_RESP_OKAY 2'h0
`define CEC_RESP_SLVERR 2'h2
`endif

/* rtl/cec_filt_if.sv */
// link between the register side and the filter chain
`timescale 1ns/1ns
interface cec_filt_if;
  import cec_pkg::*;
  logic ce;
  logic cpu_tick;
  logic raw;
  logic en;
  cec_cnt_t deb_n;
  cec_cnt_t dly_n;
  logic dly_sel;
  logic edge_sel;
  logic raw_sync;
  logic filt;
  logic delayed;
  logic edge_evt;
  modport ctrl(output ce, cpu_tick, raw, en, deb_n, dly_n, dly_sel,
    edge_sel, input raw_sync, filt, delayed, edge_evt);
  modport chain(input ce, cpu_tick, raw, en, deb_n, dly_n, dly_sel,
    edge_sel, output raw_sync, filt, delayed, edge_evt);
endinterface

/* rtl/cec_filter.sv */
// synchroniser, de-bounce, delay and edge detector of the compare result
`timescale 1ns/1ns
`include "cec_defs.svh"
module cec_filter
  import cec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control and results
  cec_filt_if.chain fi
);
  logic s1_q, s2_q, deb_q, dly_q, prev_q, edge_q;
  cec_cnt_t dcnt_q, ycnt_q;
  logic dly_tick;

  // true when one more tick completes a count of n
  function automatic logic cnt_done(input cec_cnt_t c, input cec_cnt_t n);
    cnt_done = ({1'b0, c} + 5'h01) >= {1'b0, n};
  endfunction

  // two flops: the raw result is asynchronous to our clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else if (fi.ce) begin
      s1_q <= fi.raw;
      s2_q <= s1_q;
    end
  end

  // level must hold n cpu periods before it passes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      deb_q <= 1'b0;
      dcnt_q <= 4'h0;
    end else if (fi.ce) begin
      if (!fi.en) begin
        deb_q <= 1'b0;
        dcnt_q <= 4'h0;
      end else if (s2_q == deb_q) begin
        dcnt_q <= 4'h0; // short excursion discarded
      end else if (fi.deb_n == 4'h0) begin
        deb_q <= s2_q;
      end else if (fi.cpu_tick) begin
        if (cnt_done(dcnt_q, fi.deb_n)) begin
          deb_q <= s2_q;
          dcnt_q <= 4'h0;
        end else begin
          dcnt_q <= dcnt_q + 4'h1;
        end
      end
    end
  end

  // delay clock: every hosc cycle, or cpu ticks only
  assign dly_tick = fi.dly_sel ? fi.cpu_tick : 1'b1;

  // delay stage fed by the de-bounced level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_q <= 1'b0;
      ycnt_q <= 4'h0;
    end else if (fi.ce) begin
      if (!fi.en) begin
        dly_q <= 1'b0;
        ycnt_q <= 4'h0;
      end else if (deb_q == dly_q) begin
        ycnt_q <= 4'h0;
      end else if (fi.dly_n == 4'h0) begin
        dly_q <= deb_q;
      end else if (dly_tick) begin
        if (cnt_done(ycnt_q, fi.dly_n)) begin
          dly_q <= deb_q;
          ycnt_q <= 4'h0;
        end else begin
          ycnt_q <= ycnt_q + 4'h1;
        end
      end
    end
  end

  // edge detector after both stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
      edge_q <= 1'b0;
    end else if (fi.ce) begin
      prev_q <= dly_q & fi.en;
      edge_q <= fi.en & (fi.edge_sel ? (dly_q & ~prev_q) :
        (~dly_q & prev_q));
    end
  end

  assign fi.raw_sync = s2_q;
  assign fi.filt = deb_q;
  assign fi.delayed = dly_q;
  assign fi.edge_evt = edge_q;

  // zero de-bounce passes a change on the next edge
  deb_zero_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    fi.ce && fi.en && fi.deb_n == 4'h0 && s2_q != deb_q |=>
    deb_q == $past(s2_q))
    else $error("de-bounce bypass did not pass level");

  // a rising edge under rising select flags one event
  edge_rise_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    fi.ce && fi.en && fi.edge_sel && dly_q && !prev_q |=> edge_q)
    else $error("rising edge missed");

  // no event without a change of the delayed level
  edge_cause_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    fi.ce && dly_q == prev_q |=> !edge_q)
    else $error("event without delayed edge");
endmodule

/* rtl/cec_pkg.sv */
// types shared by the edge conditioner modules
package cec_pkg;
  typedef logic [3:0] cec_cnt_t;
  typedef enum logic [2:0] {
    CEC_SEL_NONE = 3'b000,
    CEC_SEL_FILT = 3'b001,
    CEC_SEL_MODE = 3'b010,
    CEC_SEL_APIN = 3'b011,
    CEC_SEL_IRQ = 3'b100
  } cec_sel_e;
endpackage

/* rtl/cec_top.sv */
// comparator edge conditioner with its AXI4-Lite register slave
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "cec_defs.svh"
module cec_top
  import cec_pkg::*;
(
  // clock, reset, freeze
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  // instruction clock tick and analog result
  input wire logic CPU_TICK,
  input wire logic CMP_RAW,
  // pin ownership
  output logic CMP_INPUTS_EN,
  output logic RESULT_PIN_O,
  output logic RESULT_PIN_OE,
  output logic POS_ANALOG_ONLY,
  output logic NEG_ANALOG_ONLY,
  // pulse timer link
  input wire logic PULSE_BUSY,
  input wire logic SURGE_STOP,
  output logic TIMER_PULSE_OUT_EN,
  output logic TIMER_RUN_EN,
  output logic PULSE_TRIG,
  // interrupt and low power
  input wire logic GREEN_MODE,
  output logic IRQ_REQ,
  // axi4-lite write
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  cec_filt_if fi();
  cec_filter u_filter (
    .clk(REF_CLK),
    .rst_n(ARST_N),
    .fi(fi.chain)
  );

  // registers
  logic [7:0] filt_q;
  logic en_q, oen_q, spec_q, edge_sel_q, dsel_q;
  logic [1:0] apin_q;
  logic flag_q, ien_q, tpo_q, run_q;
  logic res_q, trig_q, irq_q;
  // bus state
  logic [11:0] aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_hold_q, w_hold_q, awready_q, wready_q, bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q, rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic wr_go, wr_lane0, trig_d;
  cec_sel_e wr_sel, rd_sel;
  logic [7:0] rd_byte;

  // word address to register; misaligned or unknown gives none
  function automatic cec_sel_e cec_decode(input logic [11:0] a);
    if (a[1:0] != 2'h0) begin
      cec_decode = CEC_SEL_NONE;
    end else if (a[11:2] == {2'h0, `CEC_IDX_FILTER}) begin
      cec_decode = CEC_SEL_FILT;
    end else if (a[11:2] == {2'h0, `CEC_IDX_MODE}) begin
      cec_decode = CEC_SEL_MODE;
    end else if (a[11:2] == {2'h0, `CEC_IDX_APIN}) begin
      cec_decode = CEC_SEL_APIN;
    end else if (a[11:2] == {2'h0, `CEC_IDX_IRQ}) begin
      cec_decode = CEC_SEL_IRQ;
    end else begin
      cec_decode = CEC_SEL_NONE;
    end
  endfunction

  // settings towards the filter chain
  assign fi.ce = CLK_EN;
  assign fi.cpu_tick = CPU_TICK;
  assign fi.raw = CMP_RAW; // high reads as pos above neg
  assign fi.en = en_q;
  assign fi.deb_n = filt_q[3:0];
  assign fi.dly_n = filt_q[7:4];
  assign fi.dly_sel = dsel_q;
  assign fi.edge_sel = edge_sel_q;

  // write happens once address and data are both held
  assign wr_go = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wr_lane0 = wr_go & wstrb_q[0];
  assign wr_sel = cec_decode(aw_addr_q);
  assign rd_sel = cec_decode(ARADDR);

  // write channels: address and data taken in either order
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_addr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `CEC_RESP_OKAY;
    end else if (CLK_EN) begin
      if (AWVALID && awready_q) begin
        aw_addr_q <= AWADDR;
        aw_hold_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (WVALID && wready_q) begin
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
        w_hold_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_sel == CEC_SEL_NONE) ? `CEC_RESP_SLVERR :
          `CEC_RESP_OKAY;
      end
      if (bvalid_q && BREADY) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // read data; pin config is write-only and reads zero
  always_comb begin
    rd_byte = 8'h00;
    if (rd_sel == CEC_SEL_FILT) begin
      rd_byte = filt_q;
    end else if (rd_sel == CEC_SEL_MODE) begin
      rd_byte = {en_q, oen_q, res_q, spec_q, edge_sel_q, dsel_q, 2'h0};
    end else if (rd_sel == CEC_SEL_IRQ) begin
      rd_byte = {4'h0, run_q, tpo_q, ien_q, flag_q};
    end
  end

  // read channel: one read in flight, answer one edge after address
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= `CEC_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (CLK_EN) begin
      if (ARVALID && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= {24'h00_0000, rd_byte};
        rresp_q <= (rd_sel == CEC_SEL_NONE) ? `CEC_RESP_SLVERR :
          `CEC_RESP_OKAY;
      end else if (rvalid_q && RREADY) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // software settings; surge stop overrides a write in the same cycle
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      filt_q <= `CEC_FILT_RST;
      en_q <= 1'b0;
      oen_q <= 1'b0;
      spec_q <= 1'b0;
      edge_sel_q <= 1'b0;
      dsel_q <= 1'b0;
      apin_q <= `CEC_APIN_RST;
      ien_q <= 1'b0;
      tpo_q <= 1'b0;
      run_q <= 1'b0;
    end else if (CLK_EN) begin
      if (wr_lane0 && wr_sel == CEC_SEL_FILT) begin
        filt_q <= wdata_q[7:0];
      end
      if (wr_lane0 && wr_sel == CEC_SEL_MODE) begin
        en_q <= wdata_q[`CEC_MODE_EN];
        oen_q <= wdata_q[`CEC_MODE_OEN];
        spec_q <= wdata_q[`CEC_MODE_SPEC];
        edge_sel_q <= wdata_q[`CEC_MODE_EDGE];
        dsel_q <= wdata_q[`CEC_MODE_DSEL];
      end
      if (wr_lane0 && wr_sel == CEC_SEL_APIN) begin
        apin_q <= {wdata_q[`CEC_APIN_NEG], wdata_q[`CEC_APIN_POS]};
      end
      if (wr_lane0 && wr_sel == CEC_SEL_IRQ) begin
        ien_q <= wdata_q[`CEC_IRQ_IEN];
        tpo_q <= wdata_q[`CEC_IRQ_TPO];
        run_q <= wdata_q[`CEC_IRQ_RUN];
      end
      if (SURGE_STOP) begin
        spec_q <= 1'b0;
        tpo_q <= 1'b0;
        run_q <= 1'b0;
      end
    end
  end

  // sticky event flag; writing 0 clears, a new edge wins over the clear
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flag_q <= 1'b0;
    end else if (CLK_EN) begin
      if (fi.edge_evt) begin
        flag_q <= 1'b1;
      end else if (wr_lane0 && wr_sel == CEC_SEL_IRQ &&
          !wdata_q[`CEC_IRQ_FLAG]) begin
        flag_q <= 1'b0;
      end
    end
  end

  // trigger only when armed and the timer is idle
  assign trig_d = fi.edge_evt & spec_q & tpo_q
    & ~PULSE_BUSY;

  // pin ownership, live result, trigger and interrupt request
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      res_q <= 1'b0;
      trig_q <= 1'b0;
      irq_q <= 1'b0;
      CMP_INPUTS_EN <= 1'b0;
      RESULT_PIN_O <= 1'b0;
      RESULT_PIN_OE <= 1'b0;
      POS_ANALOG_ONLY <= 1'b0;
      NEG_ANALOG_ONLY <= 1'b0;
    end else if (CLK_EN) begin
      res_q <= en_q & fi.raw_sync;
      trig_q <= trig_d;
      // green mode keeps the flag but holds back the wake request
      irq_q <= flag_q & ien_q & ~GREEN_MODE;
      CMP_INPUTS_EN <= en_q;
      RESULT_PIN_O <= en_q & oen_q & fi.filt;
      RESULT_PIN_OE <= en_q & oen_q;
      POS_ANALOG_ONLY <= apin_q[0];
      NEG_ANALOG_ONLY <= apin_q[1];
    end
  end

  assign TIMER_PULSE_OUT_EN = tpo_q;
  assign TIMER_RUN_EN = run_q;
  assign PULSE_TRIG = trig_q;
  assign IRQ_REQ = irq_q;
  assign AWREADY = awready_q;
  assign WREADY = wready_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign ARREADY = arready_q;
  assign RVALID = rvalid_q;
  assign RRESP = rresp_q;
  assign RDATA = rdata_q;

  // an armed edge with an idle timer
  sequence armed_edge_s;
    CLK_EN && fi.edge_evt && spec_q && tpo_q && !PULSE_BUSY;
  endsequence

  trig_fire_a: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    armed_edge_s |=> PULSE_TRIG ##1 (!PULSE_TRIG || !$past(CLK_EN) ||
      $past(fi.edge_evt)))
    else $error("armed edge gave no single trigger");

  trig_busy_a: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    CLK_EN && PULSE_BUSY |=> !PULSE_TRIG)
    else $error("trigger while pulse busy");

  flag_set_a: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    CLK_EN && fi.edge_evt |=> flag_q)
    else $error("edge did not set event flag");

  flag_hold_a: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    flag_q && !(wr_lane0 && wr_sel == CEC_SEL_IRQ) |=> flag_q)
    else $error("event flag dropped without software");

  irq_req_a: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    CLK_EN && flag_q && ien_q && !GREEN_MODE |=> IRQ_REQ)
    else $error("interrupt request missing");

  green_wake_a: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    CLK_EN && GREEN_MODE |=> !IRQ_REQ)
    else $error("wake request in green mode");

  surge_clr_a: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    CLK_EN && SURGE_STOP |=> !spec_q && !TIMER_PULSE_OUT_EN && !TIMER_RUN_EN)
    else $error("surge stop left timer armed");

  result_off_a: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    CLK_EN && !en_q |=> !res_q ##1 (!CLK_EN || !CMP_INPUTS_EN || en_q))
    else $error("result flag set while disabled");

  pin_own_a: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    CLK_EN && !(en_q && oen_q) |=> !RESULT_PIN_OE && !RESULT_PIN_O)
    else $error("result pin driven while not owned");

  // pin follows the de-bounced level, not the delayed one
  pin_result_a: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    CLK_EN && en_q && oen_q |=> RESULT_PIN_O == $past(fi.filt))
    else $error("result pin not the de-bounced level");
endmodule

/* test/cec_partner.sv */
// front end and pulse timer stand-in facing the edge conditioner
`timescale 1ns/1ns
module cec_partner (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // analog front end
  input wire logic above,
  output logic raw,
  // pulse timer
  input wire logic trig,
  input wire logic [7:0] width,
  output logic busy
);
  logic [7:0] cnt_q;
  // result high while the positive input sits above the negative one
  assign raw = above;
  // one pulse of programmed width per trigger; the busy level is what
  // the conditioner must honour, so triggers while busy are just dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else if (trig && cnt_q == 8'h00) begin
      cnt_q <= width;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  // busy lasts the whole pulse
  assign busy = (cnt_q != 8'h00);
endmodule

/* test/tb.sv */
// self-checking bench of the comparator edge conditioner
`timescale 1ns/1ns
`include "cec_defs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module tb;
  import cec_pkg::*;
  localparam logic [11:0] A_FILT = {2'b00, `CEC_IDX_FILTER, 2'b00};
  localparam logic [11:0] A_MODE = {2'b00, `CEC_IDX_MODE, 2'b00};
  localparam logic [11:0] A_APIN = {2'b00, `CEC_IDX_APIN, 2'b00};
  localparam logic [11:0] A_IRQ = {2'b00, `CEC_IDX_IRQ, 2'b00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tick = 1'b0;
  logic above = 1'b0;
  logic green = 1'b0;
  logic surge = 1'b0;
  logic [1:0] tdiv = 2'h0;
  logic [7:0] width = 8'h3c;
  logic busy, raw, inp_en, pin_o, pin_oe, pos_ao, neg_ao, tpo, run, trig, irq;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rdat;
  int mismatches = 0;
  int n_checks = 0;
  int trigs = 0;

  // design and far side
  cec_top i_cec_top (.REF_CLK(clk), .ARST_N(rst_n), .CLK_EN(1'b1),
    .CPU_TICK(tick), .CMP_RAW(raw), .CMP_INPUTS_EN(inp_en),
    .RESULT_PIN_O(pin_o), .RESULT_PIN_OE(pin_oe), .POS_ANALOG_ONLY(pos_ao),
    .NEG_ANALOG_ONLY(neg_ao), .PULSE_BUSY(busy), .SURGE_STOP(surge),
    .TIMER_PULSE_OUT_EN(tpo), .TIMER_RUN_EN(run), .PULSE_TRIG(trig),
    .GREEN_MODE(green), .IRQ_REQ(irq), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
  cec_partner i_cec_partner (.clk(clk), .rst_n(rst_n), .above(above),
    .raw(raw), .trig(trig), .width(width), .busy(busy));

  // 100 MHz clock
  always #5 clk = ~clk;
  // instruction tick every fourth cycle, so cpu periods differ from hosc
  always @(posedge clk) begin
    tdiv <= tdiv + 2'h1;
    tick <= (tdiv == 2'h3);
  end
  // count trigger pulses seen at the timer
  always @(posedge clk) begin
    if (trig === 1'b1) trigs++;
  end

  task automatic conclude;
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic timeout;
    mismatches++;
    $display("MISMATCH %0t bus wait ran out", $time);
    conclude();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic drive(input logic v);
    @(posedge clk);
    above <= v;
  endtask
  // cycles until irq (sel 0) or result pin (sel 1) shows v, at most n
  task automatic wsig(input int sel, input logic v, input int n,
      output int c);
    c = 0;
    while (c < n && (sel == 0 ? irq : pin_o) !== v) begin
      @(posedge clk);
      c++;
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d,
      output logic [1:0] r);
    bit done;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 0;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) timeout();
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
      output logic [1:0] r);
    bit done;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 0;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) timeout();
  endtask

  // reset values, write-only pins register, unmapped address
  task automatic s_regs;
    axi_rd(A_FILT, rdat, rs);
    `CHK(rdat, 32'h0000_0000)
    axi_rd(A_MODE, rdat, rs);
    `CHK(rdat, 32'h0000_0000)
    axi_wr(A_FILT, 8'ha5, rs);
    axi_rd(A_FILT, rdat, rs);
    `CHK(rdat, 32'h0000_00a5)
    axi_wr(A_APIN, 8'h03, rs);
    // pin flops follow one edge after the register lands
    cyc(1);
    `CHK({pos_ao, neg_ao}, 2'b11)
    axi_rd(A_APIN, rdat, rs);
    `CHK(rdat, 32'h0000_0000)
    axi_wr(12'h004, 8'hff, rs);
    `CHK(rs, `CEC_RESP_SLVERR)
    axi_rd(12'h004, rdat, rs);
    `CHK({rs, rdat}, {`CEC_RESP_SLVERR, 32'h0000_0000})
    axi_wr(A_FILT, 8'h00, rs);
  endtask
  // pin ownership and live result flag
  task automatic s_pins;
    axi_wr(A_MODE, 8'h40, rs);
    drive(1'b1);
    cyc(10);
    `CHK({inp_en, pin_oe}, 2'b00)
    axi_rd(A_MODE, rdat, rs);
    `CHK(rdat[5], 1'b0)
    axi_wr(A_MODE, 8'hc0, rs);
    cyc(10);
    `CHK({inp_en, pin_oe, pin_o}, 3'b111)
    axi_rd(A_MODE, rdat, rs);
    `CHK(rdat, 32'h0000_00e0)
    drive(1'b0);
    cyc(10);
    axi_rd(A_MODE, rdat, rs);
    `CHK({pin_o, rdat[5]}, 2'b00)
  endtask
  // both polarities, sticky flag, request and green mode
  task automatic s_edges;
    int c;
    for (int s = 0; s < 2; s++) begin
      drive(s[0]);
      axi_wr(A_MODE, {4'h8, s[0], 3'h0}, rs);
      cyc(20);
      axi_wr(A_IRQ, 8'h00, rs);
      axi_wr(A_IRQ, 8'h02, rs);
      drive(!s[0]);
      wsig(0, 1'b1, 30, c);
      `CHK(c, 30)
      drive(s[0]);
      wsig(0, 1'b1, 30, c);
      `CHK(c < 30, 1'b1)
      cyc(20);
      axi_rd(A_IRQ, rdat, rs);
      `CHK(rdat[0], 1'b1)
      green <= 1'b1;
      cyc(3);
      `CHK(irq, 1'b0)
      green <= 1'b0;
      cyc(3);
      `CHK(irq, 1'b1)
      axi_wr(A_IRQ, 8'h02, rs);
      cyc(2);
      `CHK(irq, 1'b0)
    end
  endtask
  // delay stage on both clocks, measured against no delay
  task automatic s_delay;
    int b, c;
    for (int k = 0; k < 3; k++) begin
      axi_wr(A_FILT, k == 0 ? 8'h00 : k == 1 ? 8'hf0 : 8'h30, rs);
      axi_wr(A_MODE, k == 2 ? 8'h8c : 8'h88, rs);
      drive(1'b0);
      cyc(80);
      axi_wr(A_IRQ, 8'h02, rs);
      drive(1'b1);
      wsig(0, 1'b1, 150, c);
      if (k == 0) b = c;
      // no-delay already costs one flop, so 15 periods show as 14 more;
      // cpu ticks land anywhere in their period, so allow one period
      else if (k == 1) `CHK(c - b, 14)
      else `CHK((c - b) inside {[8:11]}, 1'b1)
    end
  endtask
  // a glitch shorter than the filter never reaches the pin
  task automatic s_debounce;
    int c;
    axi_wr(A_FILT, 8'h0f, rs);
    axi_wr(A_MODE, 8'hc0, rs);
    drive(1'b0);
    cyc(100);
    drive(1'b1);
    cyc(20);
    drive(1'b0);
    wsig(1, 1'b1, 100, c);
    `CHK(c, 100)
    drive(1'b1);
    wsig(1, 1'b1, 120, c);
    `CHK(c inside {[55:66]}, 1'b1)
  endtask
  // pulse triggering, lockout while busy, flag still set
  task automatic s_special;
    axi_wr(A_FILT, 8'h00, rs);
    axi_wr(A_MODE, 8'h98, rs);
    axi_wr(A_IRQ, 8'h02, rs);
    drive(1'b0);
    cyc(20);
    trigs = 0;
    drive(1'b1);
    cyc(20);
    `CHK(trigs, 0)
    axi_wr(A_IRQ, 8'h0e, rs);
    `CHK({tpo, run}, 2'b11)
    drive(1'b0);
    cyc(20);
    drive(1'b1);
    cyc(15);
    `CHK({trigs[1:0], busy}, 3'b011)
    drive(1'b0);
    cyc(4);
    drive(1'b1);
    cyc(10);
    `CHK(trigs, 1)
    cyc(60);
    drive(1'b0);
    cyc(20);
    drive(1'b1);
    cyc(20);
    `CHK(trigs, 2)
    axi_rd(A_IRQ, rdat, rs);
    `CHK(rdat[0], 1'b1)
  endtask
  // surge stop drops special mode and timer enables
  task automatic s_surge;
    @(posedge clk);
    surge <= 1'b1;
    @(posedge clk);
    surge <= 1'b0;
    cyc(2);
    `CHK({tpo, run}, 2'b00)
    axi_rd(A_MODE, rdat, rs);
    `CHK(rdat[4], 1'b0)
    axi_rd(A_IRQ, rdat, rs);
    `CHK(rdat[3:2], 2'b00)
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    s_regs();
    s_pins();
    s_edges();
    s_delay();
    s_debounce();
    s_special();
    s_surge();
    conclude();
  end
endmodule
